// [dic_defines.vh]
// dic_defines.vh: offsets, field positions, reset values and timing counts
// for the digital input conditioner; assumes a 100 MHz core clock.
`ifndef DIC_DEFINES_VH
`define DIC_DEFINES_VH

`define DIC_CLK_HZ 100000000
`define DIC_SCAN_MS 5
`define DIC_SCAN_CYCLES (`DIC_CLK_HZ / 1000 * `DIC_SCAN_MS)
`define DIC_MS_CYCLES (`DIC_CLK_HZ / 1000)
`define DIC_AC_EXTRA_MS 30
`define DIC_AC_PCT 10

`define DIC_ACT_V_RST 9'h058
`define DIC_REL_V_RST 9'h03C
`define DIC_DLY_RST 21'h000000

// register map, byte addresses
`define DIC_OFF_ID 12'h000
`define DIC_OFF_POL 12'h004
`define DIC_OFF_ACMODE 12'h008
`define DIC_OFF_STATE 12'h00C
`define DIC_OFF_CONS 12'h010
`define DIC_OFF_RELAY 12'h014
`define DIC_OFF_CLR 12'h018
`define DIC_OFF_BASE 12'h01C
`define DIC_OFF_CH 12'h100
// per channel block of 32 bytes at DIC_OFF_CH + 32*ch
`define DIC_CH_PICK 3'h0
`define DIC_CH_DROP 3'h1
`define DIC_CH_ACTV 3'h2
`define DIC_CH_RELV 3'h3
`define DIC_CH_CNT 3'h4
`define DIC_CH_VOLT 3'h5

// device code, arbitrary value
`define DIC_ID_VALUE 32'h0D1C0001

`endif

// [dic_chan.v]
// dic_chan.v: one conditioned input channel: threshold, polarity, delays.
// assumes a scan enable pulse and a one-millisecond enable pulse.
`timescale 1ns/1ps
`include "dic_defines.vh"
module dic_chan #(
	parameter DW = 21
)(
	input wire i_clk,
	input wire i_rst_n,
	input wire i_scan,
	input wire i_ms,
	input wire i_use_volt,
	input wire i_raw,
	input wire [8:0] i_volt,
	input wire i_pol_nc,
	input wire i_ac,
	input wire [8:0] i_act_v,
	input wire [8:0] i_rel_v,
	input wire [DW-1:0] i_pick,
	input wire [DW-1:0] i_drop,
	input wire i_clr_cnt,
	output reg o_state,
	output reg [31:0] o_count
);
	localparam [DW-1:0] AC_EXTRA = `DIC_AC_EXTRA_MS;
	reg energ;
	reg next_energ;
	reg samp;
	reg [DW-1:0] tmr;
	wire [15:0] rel_ac;
	wire [8:0] rel_eff;
	wire [DW-1:0] drop_eff;
	wire [DW-1:0] target;

	assign rel_ac = ({7'h00, i_act_v} * 16'h000A) / 16'h0064;
	assign rel_eff = i_ac ? rel_ac[8:0] : i_rel_v;
	assign drop_eff = i_ac ? i_drop + AC_EXTRA : i_drop;
	assign target = samp ? i_pick : drop_eff;

	// hysteresis on measured voltage
	always @*
	begin
		next_energ = energ;
		if (!i_use_volt)
			next_energ = i_raw;
		else if (i_volt > i_act_v)
			next_energ = 1'b1;
		else if (i_volt < rel_eff)
			next_energ = 1'b0;
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			energ <= 1'b0;
		else if (i_scan)
			energ <= next_energ;
	end

	// sample once per scan, polarity applied
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			samp <= 1'b0;
		else if (i_scan)
			samp <= next_energ ^ i_pol_nc;
	end

	// pick-up / drop-off delay in ms
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_state <= 1'b0;
			tmr <= {DW{1'b0}};
		end
		else if (samp == o_state)
			tmr <= {DW{1'b0}};
		else if (tmr >= target)
		begin
			o_state <= samp;
			tmr <= {DW{1'b0}};
		end
		else if (i_ms)
			tmr <= tmr + 1'b1;
	end

	// rising-edge counter
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_count <= 32'h00000000;
		else if (i_clr_cnt)
			o_count <= 32'h00000000;
		else if (!o_state && samp && tmr >= target)
			o_count <= o_count + 32'h00000001;
	end
endmodule

// [dic_top.v]
// dic_top.v: digital input conditioner with APB register access.
// assumes pins arrive asynchronously; voltage samples are core-domain words.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dic_defines.vh"

// Functional notes
// - sample every input once per scan tick
// - polarity picks energised reads one or zero
// - rising change waits the pick-up delay
// - falling change waits the drop-off delay
// - ac mode adds thirty ms drop delay
// - consumers latch state on their scan tick
// - relay output updates one scan later
// - card inputs numbered after preceding inputs
// - thresholds programmable in one volt steps
// - above activation sets, below release clears
// - ac mode release is ten percent activation
// - per-input rising counter, software clearable
module dic_top #(
	parameter N = 8,
	parameter DW = 21,
	parameter SCAN_CYCLES = `DIC_SCAN_CYCLES,
	parameter MS_CYCLES = `DIC_MS_CYCLES
)(
	input wire i_core_clk,
	input wire i_arst_n,
	input wire [N-1:0] i_raw,
	input wire [9*N-1:0] i_volt,
	input wire i_use_volt,
	input wire [7:0] i_base_count,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	output reg [N-1:0] o_input_state,
	output reg [N-1:0] o_consumer_state,
	output reg [N-1:0] o_relay_state,
	output reg [7:0] o_first_index
);
	//////////////////////////////////////////////////////////////////////
	reg rst_s1;
	reg rst_s2;
	reg [N-1:0] raw_s1;
	reg [N-1:0] raw_s2;
	wire rst_n;

	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	assign rst_n = rst_s2;

	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			raw_s1 <= {N{1'b0}};
			raw_s2 <= {N{1'b0}};
		end
		else
		begin
			raw_s1 <= i_raw;
			raw_s2 <= raw_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// scan and millisecond enables
	reg [31:0] scan_cnt;
	reg [31:0] ms_cnt;
	reg scan_en;
	reg ms_en;

	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scan_cnt <= 32'h00000000;
			ms_cnt <= 32'h00000000;
			scan_en <= 1'b0;
			ms_en <= 1'b0;
		end
		else
		begin
			scan_en <= 1'b0;
			ms_en <= 1'b0;
			if (scan_cnt == SCAN_CYCLES - 1)
			begin
				scan_cnt <= 32'h00000000;
				scan_en <= 1'b1;
			end
			else
				scan_cnt <= scan_cnt + 32'h00000001;
			if (ms_cnt == MS_CYCLES - 1)
			begin
				ms_cnt <= 32'h00000000;
				ms_en <= 1'b1;
			end
			else
				ms_cnt <= ms_cnt + 32'h00000001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// configuration registers
	reg [N-1:0] pol_nc;
	reg [N-1:0] ac_mode;
	reg [N-1:0] clr_pulse;
	reg [DW-1:0] pick [0:N-1];
	reg [DW-1:0] drop [0:N-1];
	reg [8:0] act_v [0:N-1];
	reg [8:0] rel_v [0:N-1];
	wire [N-1:0] state;
	wire [32*N-1:0] counts;
	wire wr_en;
	wire wr_take;
	wire rd_en;
	wire ch_hit;
	wire [2:0] ch_idx;
	wire [2:0] ch_reg;
	integer k;

	function [31:0] widen9;
		input [8:0] v;
		begin
			widen9 = {23'h000000, v};
		end
	endfunction

	// writes land on the completing edge, errors flagged one edge before
	assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
	assign wr_take = i_psel && i_penable && i_pwrite && !o_pready;
	assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;
	assign ch_hit = i_paddr[11:8] == `DIC_OFF_CH >> 8 && i_paddr[4:2] <= 3'h5
		&& i_paddr[1:0] == 2'h0 && {5'h00, i_paddr[7:5]} < N;
	assign ch_idx = i_paddr[7:5];
	assign ch_reg = i_paddr[4:2];

	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pol_nc <= {N{1'b0}};
			ac_mode <= {N{1'b0}};
			clr_pulse <= {N{1'b0}};
			for (k = 0; k < N; k = k + 1)
			begin
				pick[k] <= `DIC_DLY_RST;
				drop[k] <= `DIC_DLY_RST;
				act_v[k] <= `DIC_ACT_V_RST;
				rel_v[k] <= `DIC_REL_V_RST;
			end
		end
		else
		begin
			clr_pulse <= {N{1'b0}};
			if (wr_en && i_paddr == `DIC_OFF_POL)
				pol_nc <= i_pwdata[N-1:0];
			if (wr_en && i_paddr == `DIC_OFF_ACMODE)
				ac_mode <= i_pwdata[N-1:0];
			if (wr_en && i_paddr == `DIC_OFF_CLR)
				clr_pulse <= i_pwdata[N-1:0];
			if (wr_en && ch_hit)
			begin
				case (ch_reg)
				`DIC_CH_PICK: pick[ch_idx] <= i_pwdata[DW-1:0];
				`DIC_CH_DROP: drop[ch_idx] <= i_pwdata[DW-1:0];
				`DIC_CH_ACTV: act_v[ch_idx] <= i_pwdata[8:0];
				`DIC_CH_RELV: rel_v[ch_idx] <= i_pwdata[8:0];
				default: ;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// channels
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1)
		begin : gen_ch
			dic_chan #(
				.DW(DW)
			) u_chan (
				.i_clk(i_core_clk),
				.i_rst_n(rst_n),
				.i_scan(scan_en),
				.i_ms(ms_en),
				.i_use_volt(i_use_volt),
				.i_raw(raw_s2[g]),
				.i_volt(i_volt[9*g+8:9*g]),
				.i_pol_nc(pol_nc[g]),
				.i_ac(ac_mode[g]),
				.i_act_v(act_v[g]),
				.i_rel_v(rel_v[g]),
				.i_pick(pick[g]),
				.i_drop(drop[g]),
				.i_clr_cnt(clr_pulse[g]),
				.o_state(state[g]),
				.o_count(counts[32*g+31:32*g])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// downstream scan stages
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_input_state <= {N{1'b0}};
			o_consumer_state <= {N{1'b0}};
			o_relay_state <= {N{1'b0}};
			o_first_index <= 8'h00;
		end
		else
		begin
			o_input_state <= state;
			o_first_index <= i_base_count + 8'h01;
			if (scan_en)
			begin
				o_consumer_state <= o_input_state;
				o_relay_state <= o_consumer_state;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, reads registered
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end
		else
		begin
			o_pready <= i_psel && i_penable && !o_pready;
			o_pslverr <= 1'b0;
			if (rd_en)
			begin
				o_prdata <= 32'h00000000;
				if (ch_hit)
				begin
					case (ch_reg)
					`DIC_CH_PICK: o_prdata <= {{(32-DW){1'b0}}, pick[ch_idx]};
					`DIC_CH_DROP: o_prdata <= {{(32-DW){1'b0}}, drop[ch_idx]};
					`DIC_CH_ACTV: o_prdata <= widen9(act_v[ch_idx]);
					`DIC_CH_RELV: o_prdata <= widen9(rel_v[ch_idx]);
					`DIC_CH_CNT: o_prdata <= counts[32*ch_idx+:32];
					`DIC_CH_VOLT: o_prdata <= widen9(i_volt[9*ch_idx+:9]);
					default: o_prdata <= 32'h00000000;
					endcase
				end
				else
				begin
					case (i_paddr)
					`DIC_OFF_ID: o_prdata <= `DIC_ID_VALUE;
					`DIC_OFF_POL: o_prdata <= {{(32-N){1'b0}}, pol_nc};
					`DIC_OFF_ACMODE: o_prdata <= {{(32-N){1'b0}}, ac_mode};
					`DIC_OFF_STATE: o_prdata <= {{(32-N){1'b0}}, o_input_state};
					`DIC_OFF_CONS: o_prdata <= {{(32-N){1'b0}}, o_consumer_state};
					`DIC_OFF_RELAY: o_prdata <= {{(32-N){1'b0}}, o_relay_state};
					`DIC_OFF_CLR: o_prdata <= 32'h00000000;
					`DIC_OFF_BASE: o_prdata <= {24'h000000, o_first_index};
					default: o_pslverr <= 1'b1;
					endcase
				end
			end
			else if (wr_take && !ch_hit && i_paddr != `DIC_OFF_POL
				&& i_paddr != `DIC_OFF_ACMODE && i_paddr != `DIC_OFF_CLR)
				o_pslverr <= 1'b1;
		end
	end
endmodule

// [dic_field_model.sv]
// dic_field_model.sv: field side of the isolated input channels.
// assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ps
module dic_field_model (
	output logic [7:0] o_raw,
	output logic [71:0] o_volt
);
	initial
	begin
		o_raw = 8'h00;
		o_volt = 72'h0;
	end
	task automatic lvl(input int c, input logic v);
		o_raw[c] <= v;
	endtask
	task automatic vlt(input int c, input logic [8:0] v);
		o_volt[9*c+:9] <= v;
	endtask
endmodule

// [dic_top_asserts.sv]
// dic_top_asserts.sv: port checks for the input conditioner.
// assumes it is bound into every dic_top instance.
`timescale 1ns/1ps
`include "dic_defines.vh"
module dic_top_chk #(
	parameter N = 8
)(
	input wire i_core_clk,
	input wire i_arst_n,
	input wire [7:0] i_base_count,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] o_prdata,
	input wire o_pready,
	input wire o_pslverr,
	input wire [N-1:0] o_input_state,
	input wire [N-1:0] o_consumer_state,
	input wire [N-1:0] o_relay_state,
	input wire [7:0] o_first_index
);
	// mirror of the design's two-stage reset release
	logic rst_q1;
	logic rst_ok;
	always @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_q1 <= 1'b0;
			rst_ok <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_ok <= rst_q1;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_ok);
	sequence s_take;
		i_psel && i_penable && !o_pready;
	endsequence
	property p_answer;
		s_take |=> o_pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready");
	property p_pulse;
		o_pready |=> !o_pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unmap;
		s_take ##0 (i_paddr >= 12'h020 && i_paddr < 12'h100) |=> o_pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("no error");
	property p_id;
		s_take ##0 (!i_pwrite && i_paddr == `DIC_OFF_ID)
			|=> o_prdata == `DIC_ID_VALUE;
	endproperty
	a_id: assert property (p_id) else $error("bad id");
	property p_cons;
		!$stable(o_consumer_state) |-> o_consumer_state == $past(o_input_state);
	endproperty
	a_cons: assert property (p_cons) else $error("bad consumer");
	property p_relay;
		!$stable(o_relay_state) |-> o_relay_state == $past(o_consumer_state);
	endproperty
	a_relay: assert property (p_relay) else $error("bad relay");
	property p_first;
		$stable(i_base_count)[*4] |-> o_first_index == i_base_count + 8'h01;
	endproperty
	a_first: assert property (p_first) else $error("bad index");
endmodule
////////////////////////////////
bind dic_top dic_top_chk #(.N(N)) u_chk (.i_core_clk, .i_arst_n,
	.i_base_count, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
	.o_pready, .o_pslverr, .o_input_state, .o_consumer_state,
	.o_relay_state, .o_first_index);

// [test_digital_input_conditioner.sv]
// test_digital_input_conditioner.sv: self-checking bench for dic_top.
// assumes shortened scan and millisecond counts.
`timescale 1ns/1ps
`include "dic_defines.vh"
module test_digital_input_conditioner;
	localparam SC = 20;
	localparam MS = 4;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic use_v = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic [31:0] rd;
	logic prdy, perr, er;
	logic [7:0] raw, ist, cst, rly, fidx;
	logic [71:0] volt;
	int miscompares = 0;
	int n_compared = 0;
	int n;
	always #5 clk = ~clk;
	dic_field_model u_fld (.o_raw(raw), .o_volt(volt));
	dic_top #(.SCAN_CYCLES(SC), .MS_CYCLES(MS)) u_dut (
		.i_core_clk(clk), .i_arst_n(arst_n), .i_raw(raw), .i_volt(volt),
		.i_use_volt(use_v), .i_base_count(8'h05), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
		.o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
		.o_input_state(ist), .o_consumer_state(cst),
		.o_relay_state(rly), .o_first_index(fidx));
	////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", s, e, g);
			miscompares++;
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (prdy !== 1'b1 && k < 50);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1)
		begin
			$display("[FAIL] apb ready expected 1 seen %b", prdy);
			miscompares++;
			end_sim();
		end
	endtask
	// wait on state (0), consumer (1) or relay (2) bit
	task automatic wt(input int s, b, input logic v, input int lim);
		logic [7:0] x;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			x = (s == 0) ? ist : (s == 1) ? cst : rly;
		end
		while (x[b] !== v && n < lim);
		if (x[b] !== v)
		begin
			$display("[FAIL] wait bit %0d expected %b seen %b", b, v, x[b]);
			miscompares++;
			end_sim();
		end
	endtask
	task automatic hold(input int b, input logic v, input int c);
		int bad;
		bad = 0;
		repeat (c)
		begin
			@(posedge clk);
			if (ist[b] !== v)
				bad++;
		end
		chk("hold", 0, bad);
	endtask
	////////////////////////////////
	task automatic t_regs;
		apb(0, `DIC_OFF_ID, 0);
		chk("id", `DIC_ID_VALUE, rd);
		apb(0, `DIC_OFF_POL, 0);
		chk("polarity", 0, rd);
		apb(0, `DIC_OFF_ACMODE, 0);
		chk("ac mode", 0, rd);
		apb(0, 12'h160, 0);
		chk("pick", 0, rd);
		apb(0, 12'h164, 0);
		chk("drop", 0, rd);
		apb(0, 12'h16C, 0);
		chk("release", 32'h3C, rd);
		apb(0, 12'h168, 0);
		chk("activate", 32'h58, rd);
		apb(1, 12'h168, 32'h65);
		apb(0, 12'h168, 0);
		chk("activate", 32'h65, rd);
		apb(0, 12'h020, 0);
		chk("unmapped", 1, er);
		apb(0, `DIC_OFF_BASE, 0);
		chk("first", 6, rd);
		chk("first port", 6, fidx);
		$display("test regs done");
	endtask
	task automatic t_pick;
		apb(1, 12'h100, 10);
		u_fld.lvl(0, 1'b1);
		repeat (20) @(posedge clk);
		u_fld.lvl(0, 1'b0);
		hold(0, 1'b0, 80);
		u_fld.lvl(0, 1'b1);
		wt(0, 0, 1'b1, 200);
		chk("pick time", 1, n >= 10 * MS && n <= 11 * MS + SC + 4);
		$display("test pick done");
	endtask
	task automatic t_drop;
		apb(1, 12'h104, 1);
		apb(1, `DIC_OFF_ACMODE, 1);
		u_fld.lvl(0, 1'b0);
		wt(0, 0, 1'b0, 300);
		chk("drop time", 1, n >= 31 * MS && n <= 32 * MS + SC + 4);
		$display("test drop done");
	endtask
	task automatic t_pol;
		apb(1, `DIC_OFF_POL, 2);
		wt(0, 1, 1'b1, SC + 6);
		wt(1, 1, 1'b1, SC + 2);
		wt(2, 1, 1'b1, SC + 2);
		u_fld.lvl(1, 1'b1);
		wt(0, 1, 1'b0, SC + 6);
		$display("test polarity done");
	endtask
	task automatic t_volt;
		use_v <= 1'b1;
		u_fld.vlt(2, 9'd100);
		wt(0, 2, 1'b1, SC + 6);
		u_fld.vlt(2, 9'd70);
		hold(2, 1'b1, 2 * SC);
		u_fld.vlt(2, 9'd50);
		wt(0, 2, 1'b0, SC + 6);
		apb(0, 12'h150, 0);
		chk("count", 1, rd);
		apb(1, `DIC_OFF_CLR, 4);
		apb(0, 12'h150, 0);
		chk("cleared", 0, rd);
		apb(1, `DIC_OFF_ACMODE, 5);
		u_fld.vlt(2, 9'd100);
		wt(0, 2, 1'b1, SC + 6);
		u_fld.vlt(2, 9'd9);
		hold(2, 1'b1, 200);
		u_fld.vlt(2, 9'd7);
		wt(0, 2, 1'b0, 200);
		$display("test voltage done");
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_pick();
		t_drop();
		t_pol();
		t_volt();
		end_sim();
	end
endmodule
